// file: rtl/irq_bank_if.sv
// carrier between the controller and its request flag bank
`timescale 1ns/100ps
interface irq_bank_if #(parameter int N = 4);
  logic [N-1:0] event_hit;
  logic [N-1:0] enable;
  logic wr;
  logic [N-1:0] wdata;
  logic [N-1:0] flags;
  logic [N-1:0] pending;
  modport bank (input event_hit, enable, wr, wdata, output flags, pending);
  modport ctrl (output event_hit, enable, wr, wdata, input flags, pending);
endinterface : irq_bank_if

// file: rtl/irq_controller.sv
// interrupt controller: flags, enables, global enable, vectoring, save buffer
//
// What this block does
// - pin flag sets on the selected edge whatever its enable.
// - enabled pin edge redirects the core to vector 8.
// - edge field bits 4:3: 01 rise, 10 fall, 11 both, 00 none.
// - matching pin edge during power down is latched, when pin enable bit 0 is set, and serviced first.
// - entering service clears the global enable.
// - leaving service sets the global enable again.
// - taking an interrupt adds one stack level and jumps to 8.
// - no vectoring unless global enable bit 7 is 1; it resets to 0.
// - enable bits 0 pin, 4 basic timer, 5 timer/counter, 7 converter; reset 0.
// - flags stay set until software writes them clear.
// - basic timer overflow sets its flag; vectors only when enabled.
// - timer/counter overflow sets its flag; vectors when enabled.
// - a flag set while disabled never vectors after a later enable, except when its set meets a same-cycle clear of the still-armed flag.
// - service ends only on the return-from-interrupt instruction.
// - one-level save buffer for accumulator and program flags.
// - save and restore leave timeout and power-down status bits alone.
// - conversion end sets converter flag; vectors only when enabled.
// - any wake-up from power down returns to normal mode.
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
module irq_controller (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [irq_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // event sources on this clock
  input wire logic i_basic_timer_ovf,
  input wire logic i_timer_counter_ovf,
  input wire logic i_converter_done,
  // external interrupt pin, asynchronous
  input wire logic i_external_pin_irq,
  // core sequencer
  input wire logic i_core_accept,
  input wire logic i_return_from_irq,
  input wire logic i_powerdown_enter,
  input wire logic i_save,
  input wire logic i_restore,
  input wire logic [7:0] i_accumulator,
  input wire logic [7:0] i_program_flags,
  output logic o_core_irq,
  output logic o_vector_load,
  output logic [irq_pkg::PC_W-1:0] o_vector_addr,
  output logic o_wake,
  output logic o_normal_mode,
  output logic o_wake_irq_first,
  output logic o_restore_valid,
  output logic [7:0] o_restore_accumulator,
  output logic [7:0] o_restore_program_flags
);
  typedef struct packed {
    irq_pkg::core_state_t mode;
    logic [1:0] edge_field;
    logic [irq_pkg::SRC_N-1:0] enable;
    logic global_irq_enable;
    logic [2:0] stack_level;
    logic [2:0] pin_sync;
    logic wake_latch;
    logic vector_load;
    logic wake;
    logic [7:0] save_acc;
    logic [7:0] save_pflags;
    logic restore_valid;
    logic [7:0] restore_acc;
    logic [7:0] restore_pflags;
    logic [31:0] rdata;
    logic slverr;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic [1:0] rst_sync;
  logic rst_n;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  irq_bank_if #(.N(irq_pkg::SRC_N)) bank ();

  irq_flag_bank #(.N(irq_pkg::SRC_N)) u_bank (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .bus(bank)
  );

  logic setup;
  logic access;
  logic [7:0] idx;
  logic hit_edge;
  logic hit_flags;
  logic hit_en;
  logic hit_stack_pointer_global_enable;
  logic hit_save;
  logic pin_rise;
  logic pin_fall;
  logic pin_match;
  logic any_pending;
  logic take;
  logic [7:0] flags_byte;
  logic [7:0] en_byte;

  assign setup = i_psel && !i_penable;
  // writes land at the access edge, where pready is sampled high
  assign access = i_psel && i_penable;
  assign idx = i_paddr[irq_pkg::ADDR_W-1:2];
  assign hit_edge = (idx == irq_pkg::IDX_EDGE);
  assign hit_flags = (idx == irq_pkg::IDX_FLAGS);
  assign hit_en = (idx == irq_pkg::IDX_EN);
  assign hit_stack_pointer_global_enable = (idx == irq_pkg::IDX_STACK_POINTER_GLOBAL_ENABLE);
  assign hit_save = (idx == irq_pkg::IDX_SAVE);

  // pin_sync[0] feeds only pin_sync[1]; edges compare stages 1 and 2
  assign pin_rise = st.pin_sync[1] && !st.pin_sync[2];
  assign pin_fall = !st.pin_sync[1] && st.pin_sync[2];
  always_comb begin
    unique case (irq_pkg::edge_mode_t'(st.edge_field))
      irq_pkg::EDGE_RISE: pin_match = pin_rise;
      irq_pkg::EDGE_FALL: pin_match = pin_fall;
      irq_pkg::EDGE_BOTH: pin_match = pin_rise | pin_fall;
      irq_pkg::EDGE_NONE: pin_match = 1'b0;
    endcase
  end

  // flag bank hookup; each event sets its flag whatever the enable
  always_comb begin
    bank.event_hit = '0;
    bank.event_hit[0] = pin_match;
    bank.event_hit[1] = i_basic_timer_ovf;
    bank.event_hit[2] = i_timer_counter_ovf;
    bank.event_hit[3] = i_converter_done;
    bank.enable = st.enable;
    bank.wr = access && i_pwrite && hit_flags;
    bank.wdata = {i_pwdata[irq_pkg::BIT_ADC], i_pwdata[irq_pkg::BIT_TC],
                  i_pwdata[irq_pkg::BIT_BT], i_pwdata[irq_pkg::BIT_PIN]};
  end

  always_comb begin
    flags_byte = irq_pkg::BYTE_ZERO;
    flags_byte[irq_pkg::BIT_PIN] = bank.flags[0];
    flags_byte[irq_pkg::BIT_BT] = bank.flags[1];
    flags_byte[irq_pkg::BIT_TC] = bank.flags[2];
    flags_byte[irq_pkg::BIT_ADC] = bank.flags[3];
    en_byte = irq_pkg::BYTE_ZERO;
    en_byte[irq_pkg::BIT_PIN] = st.enable[0];
    en_byte[irq_pkg::BIT_BT] = st.enable[1];
    en_byte[irq_pkg::BIT_TC] = st.enable[2];
    en_byte[irq_pkg::BIT_ADC] = st.enable[3];
  end

  assign any_pending = |bank.pending;
  assign o_core_irq = any_pending && st.global_irq_enable
                      && (st.mode == irq_pkg::ST_RUN);
  assign take = o_core_irq && i_core_accept;

  always_comb begin
    next_st = st;
    next_st.pin_sync = {st.pin_sync[1:0], i_external_pin_irq};
    next_st.vector_load = 1'b0;
    next_st.wake = 1'b0;
    next_st.restore_valid = 1'b0;

    // register writes, taken in the access cycle
    if (access && i_pwrite) begin
      if (hit_edge) begin
        next_st.edge_field = i_pwdata[irq_pkg::EDGE_HI:irq_pkg::EDGE_LO];
      end
      if (hit_en) begin
        next_st.enable = {i_pwdata[irq_pkg::BIT_ADC], i_pwdata[irq_pkg::BIT_TC],
                          i_pwdata[irq_pkg::BIT_BT], i_pwdata[irq_pkg::BIT_PIN]};
      end
      if (hit_stack_pointer_global_enable) begin
        next_st.global_irq_enable = i_pwdata[irq_pkg::GIE_BIT];
        next_st.stack_level = i_pwdata[irq_pkg::STK_HI:0];
      end
    end

    // read data captured in setup so it is stable in the access phase
    if (setup) begin
      next_st.slverr = !(hit_edge || hit_flags || hit_en || hit_stack_pointer_global_enable || hit_save);
      next_st.rdata = '0;
      if (!i_pwrite) begin
        if (hit_edge) begin
          next_st.rdata[irq_pkg::EDGE_HI:irq_pkg::EDGE_LO] = st.edge_field;
        end
        if (hit_flags) begin
          next_st.rdata[7:0] = flags_byte;
        end
        if (hit_en) begin
          next_st.rdata[7:0] = en_byte;
        end
        if (hit_stack_pointer_global_enable) begin
          next_st.rdata[irq_pkg::GIE_BIT] = st.global_irq_enable;
          next_st.rdata[irq_pkg::STK_HI:0] = st.stack_level;
        end
        if (hit_save) begin
          next_st.rdata[15:0] = {st.save_pflags, st.save_acc};
        end
      end
    end

    // core sequence; hardware updates win over a same-cycle register write
    unique case (st.mode)
      irq_pkg::ST_RUN: begin
        if (take) begin
          next_st.global_irq_enable = 1'b0;
          next_st.stack_level = st.stack_level + irq_pkg::STK_STEP;
          next_st.vector_load = 1'b1;
          next_st.wake_latch = 1'b0;
          next_st.mode = irq_pkg::ST_SERVICE;
        end else if (i_powerdown_enter) begin
          next_st.mode = irq_pkg::ST_ASLEEP;
        end
      end
      irq_pkg::ST_SERVICE: begin
        if (i_return_from_irq) begin
          next_st.global_irq_enable = 1'b1;
          next_st.stack_level = st.stack_level - irq_pkg::STK_STEP;
          next_st.mode = irq_pkg::ST_RUN;
        end
      end
      irq_pkg::ST_ASLEEP: begin
        // any synced edge wakes; only a matching enabled edge is latched
        if (pin_rise || pin_fall) begin
          next_st.wake = 1'b1;
          next_st.mode = irq_pkg::ST_RUN;
          next_st.wake_latch = pin_match && st.enable[0];
        end
      end
      default: begin
        next_st.mode = irq_pkg::ST_RUN;
      end
    endcase

    // one-level save buffer, status bits excluded
    if (i_save) begin
      next_st.save_acc = i_accumulator;
      next_st.save_pflags = i_program_flags & ~irq_pkg::PF_STATUS_MASK;
    end
    if (i_restore) begin
      next_st.restore_valid = 1'b1;
      next_st.restore_acc = st.save_acc;
      next_st.restore_pflags = (st.save_pflags & ~irq_pkg::PF_STATUS_MASK)
                               | (i_program_flags & irq_pkg::PF_STATUS_MASK);
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mode <= irq_pkg::ST_RUN;
      st.edge_field <= irq_pkg::EDGE_RST;
      st.stack_level <= irq_pkg::STK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign o_prdata = st.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && st.slverr;
  assign o_vector_load = st.vector_load;
  assign o_vector_addr = irq_pkg::VECTOR_ADDR;
  assign o_wake = st.wake;
  assign o_normal_mode = (st.mode != irq_pkg::ST_ASLEEP);
  assign o_wake_irq_first = st.wake_latch;
  assign o_restore_valid = st.restore_valid;
  assign o_restore_accumulator = st.restore_acc;
  assign o_restore_program_flags = st.restore_pflags;

  gie_clear_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    take |=> !st.global_irq_enable && st.vector_load) else $error("gie not cleared");
  gie_set_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (st.mode == irq_pkg::ST_SERVICE && i_return_from_irq) |=> st.global_irq_enable)
    else $error("gie not restored");
  stack_push_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    take |=> st.stack_level == $past(st.stack_level) + irq_pkg::STK_STEP)
    else $error("stack not pushed");
  stack_pop_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (st.mode == irq_pkg::ST_SERVICE && i_return_from_irq)
      |=> st.stack_level == $past(st.stack_level) - irq_pkg::STK_STEP)
    else $error("stack not popped");
  gie_gate_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    !st.global_irq_enable |-> !o_core_irq) else $error("irq without gie");
  vector_gate_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_vector_load |-> $past(st.global_irq_enable) && $past(any_pending))
    else $error("vector without enabled request");
  gie_write_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (access && i_pwrite && hit_stack_pointer_global_enable && st.mode == irq_pkg::ST_RUN && !take)
      |=> st.global_irq_enable == $past(i_pwdata[irq_pkg::GIE_BIT]))
    else $error("global enable write lost");
  en_write_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (access && i_pwrite && hit_en) |=> st.enable[0] == $past(i_pwdata[irq_pkg::BIT_PIN])
      && st.enable[3] == $past(i_pwdata[irq_pkg::BIT_ADC]))
    else $error("enable write lost");
  service_hold_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (st.mode == irq_pkg::ST_SERVICE && !i_return_from_irq) |=> st.mode == irq_pkg::ST_SERVICE)
    else $error("service left early");
  pin_flag_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    pin_match |=> bank.flags[0]) else $error("pin flag missed");
  timer_flag_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_basic_timer_ovf |=> bank.flags[1]) else $error("basic timer flag missed");
  tc_flag_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_timer_counter_ovf |=> bank.flags[2]) else $error("timer/counter flag missed");
  adc_flag_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_converter_done && !st.enable[3] |=> bank.flags[3] && !bank.pending[3])
    else $error("converter flag wrong");
  wake_normal_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    st.wake |-> o_normal_mode && $past(st.mode) == irq_pkg::ST_ASLEEP)
    else $error("wake not to normal");
  wake_latch_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (st.mode == irq_pkg::ST_ASLEEP && pin_match && st.enable[0])
      |=> o_wake_irq_first && bank.flags[0]) else $error("wake edge not latched");
  save_strip_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_save |=> (st.save_pflags & irq_pkg::PF_STATUS_MASK) == irq_pkg::BYTE_ZERO
      && st.save_acc == $past(i_accumulator)) else $error("save buffer wrong");
  restore_data_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_restore |=> o_restore_valid && o_restore_accumulator == $past(st.save_acc))
    else $error("restore data wrong");
  restore_keep_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_restore |=> (o_restore_program_flags & irq_pkg::PF_STATUS_MASK)
      == ($past(i_program_flags) & irq_pkg::PF_STATUS_MASK))
    else $error("status bits not kept");
endmodule : irq_controller

// file: rtl/irq_flag_bank.sv
// sticky request flags with per-source arming
`timescale 1ns/100ps
module irq_flag_bank #(
  parameter int N = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  irq_bank_if.bank bus
);
  typedef struct packed {
    logic [N-1:0] flag;
    logic [N-1:0] armed;
  } bank_state_t;

  bank_state_t st;
  bank_state_t next_st;

  always_comb begin
    next_st = st;
    for (int i = 0; i < N; i++) begin
      if (bus.wr) begin
        next_st.flag[i] = bus.wdata[i];
        if (!bus.wdata[i]) begin
          next_st.armed[i] = 1'b0;
        end
      end
      // event beats software clear in the same cycle
      if (bus.event_hit[i]) begin
        next_st.flag[i] = 1'b1;
        // a flag raised while disabled keeps its previous arming, even over a same-cycle clear
        next_st.armed[i] = st.armed[i] | bus.enable[i];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.flags = st.flag;
  assign bus.pending = st.flag & st.armed & bus.enable;

  set_wins_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bus.event_hit != '0) |=> ((bus.flags & $past(bus.event_hit)) == $past(bus.event_hit)))
    else $error("event lost against clear");
  unarmed_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ((bus.enable == '0) && !bus.wr) |=> (bus.pending == '0 || $past(bus.event_hit) == '0
      || $past(bus.enable) != '0 || (bus.pending & ~$past(bus.flags)) == '0))
    else $error("flag set while disabled became pending");
endmodule : irq_flag_bank

// file: rtl/irq_pkg.sv
// constants and types shared by the interrupt controller files
package irq_pkg;
  localparam int ADDR_W = 10;
  localparam int SRC_N = 4;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_EDGE = 8'hbf;
  localparam logic [7:0] IDX_FLAGS = 8'hc8;
  localparam logic [7:0] IDX_EN = 8'hc9;
  localparam logic [7:0] IDX_STACK_POINTER_GLOBAL_ENABLE = 8'hdf;
  localparam logic [7:0] IDX_SAVE = 8'he0;
  // bit positions of the four sources in flags and enables
  localparam int BIT_PIN = 0;
  localparam int BIT_BT = 4;
  localparam int BIT_TC = 5;
  localparam int BIT_ADC = 7;
  localparam int GIE_BIT = 7;
  localparam int EDGE_LO = 3;
  localparam int EDGE_HI = 4;
  localparam int STK_HI = 2;
  localparam logic [1:0] EDGE_RST = 2'h2;
  localparam logic [2:0] STK_RST = 3'h7;
  localparam logic [2:0] STK_STEP = 3'h1;
  localparam int PC_W = 12;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 12'h008;
  // timeout and power-down status bits of the program flags
  localparam logic [7:0] PF_STATUS_MASK = 8'hc0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SERVICE = 2'h1,
    ST_ASLEEP = 2'h2
  } core_state_t;
endpackage : irq_pkg

// file: test/core_model.sv
// core sequencer model: takes a pending request after a set lag
`timescale 1ns/100ps
module core_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_irq,
  input wire logic i_auto,
  input wire logic [3:0] i_lag,
  output logic o_accept
);
  logic [3:0] wait_cnt;
  // one accept per request; the lag makes the core slow on purpose
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_accept <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      o_accept <= 1'b0;
      if (i_auto && i_irq === 1'b1 && !o_accept) begin
        if (wait_cnt >= i_lag) begin
          o_accept <= 1'b1;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule : core_model

// file: test/irq_controller_test.sv
// register and core-handshake tests of the interrupt controller
`timescale 1ns/100ps
module irq_controller_test;
  localparam logic [9:0] A_EDGE = {irq_pkg::IDX_EDGE, 2'h0};
  localparam logic [9:0] A_FLAGS = {irq_pkg::IDX_FLAGS, 2'h0};
  localparam logic [9:0] A_EN = {irq_pkg::IDX_EN, 2'h0};
  localparam logic [9:0] A_STACK_POINTER_GLOBAL_ENABLE = {irq_pkg::IDX_STACK_POINTER_GLOBAL_ENABLE, 2'h0};
  localparam logic [9:0] A_SAVE = {irq_pkg::IDX_SAVE, 2'h0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] ev = 3'h0;
  logic [3:0] ctl_v = 4'h0;
  logic pin = 1'b1;
  logic auto = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [7:0] acc = 8'h00;
  logic [7:0] pf = 8'h00;
  logic accept;
  logic [31:0] prdata;
  logic pready, pslverr, core_irq, vector_load, wake, normal_mode, irq_first, rvalid;
  logic [11:0] vector_addr;
  logic [7:0] racc, rpf;
  logic [31:0] rdata;
  logic perr;
  int errors = 0;
  int samples_checked = 0;

  always #2 clk = ~clk;

  irq_controller dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_basic_timer_ovf(ev[0]),
    .i_timer_counter_ovf(ev[1]), .i_converter_done(ev[2]),
    .i_external_pin_irq(pin), .i_core_accept(accept), .i_return_from_irq(ctl_v[0]),
    .i_powerdown_enter(ctl_v[1]), .i_save(ctl_v[2]), .i_restore(ctl_v[3]),
    .i_accumulator(acc), .i_program_flags(pf), .o_core_irq(core_irq),
    .o_vector_load(vector_load), .o_vector_addr(vector_addr), .o_wake(wake),
    .o_normal_mode(normal_mode), .o_wake_irq_first(irq_first),
    .o_restore_valid(rvalid), .o_restore_accumulator(racc),
    .o_restore_program_flags(rpf)
  );

  core_model core_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_irq(core_irq), .i_auto(auto), .i_lag(lag),
    .o_accept(accept)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      input logic [2:0] e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    ev <= e;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ev <= 3'h0;
    #1;
  endtask : xfer

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 3'h0);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 3'h0);
    check(rdata, exp);
  endtask : rd

  task automatic pulse(input logic [2:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 3'h0;
    #1;
  endtask : pulse

  // v bits: restore, save, power down, return
  task automatic ctl(input logic [3:0] v, input logic [7:0] a, input logic [7:0] f);
    @(posedge clk);
    ctl_v <= v;
    acc <= a;
    pf <= f;
    @(posedge clk);
    ctl_v <= 4'h0;
    #1;
  endtask : ctl

  task automatic set_pin(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (6) @(posedge clk);
    #1;
  endtask : set_pin

  task automatic await(input int k);
    int n;
    n = 0;
    while (n < 40 && (k == 0 ? vector_load : wake) !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : await

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  initial begin
    #40000;
    errors++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_EDGE, 32'h10);
    rd(A_FLAGS, 32'h0);
    rd(A_EN, 32'h0);
    rd(A_STACK_POINTER_GLOBAL_ENABLE, 32'h07);
    rd(10'h000, 32'h0);
    check(perr, 1'b1);
    check(pready, 1'b1);
    $display("test reset values done");
    wr(A_EN, 32'h10);
    pulse(3'h1);
    check(core_irq, 1'b0);
    rd(A_FLAGS, 32'h10);
    wr(A_STACK_POINTER_GLOBAL_ENABLE, 32'h87);
    check(core_irq, 1'b1);
    wr(A_FLAGS, 32'h0);
    check(core_irq, 1'b0);
    wr(A_EN, 32'h0);
    pulse(3'h2);
    rd(A_FLAGS, 32'h20);
    wr(A_EN, 32'h20);
    check(core_irq, 1'b0);
    wr(A_EN, 32'h0);
    xfer(1'b1, A_FLAGS, 32'h0, 3'h2);
    rd(A_FLAGS, 32'h20);
    wr(A_FLAGS, 32'h0);
    $display("test flags and gating done");
    @(posedge clk);
    auto <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      lag <= 4'(i * 3);
      wr(A_EN, (i == 2) ? 32'h80 : (32'h10 << i));
      pulse(3'h1 << i);
      await(0);
      check(vector_load, 1'b1);
      check(vector_addr, 32'h8);
      check(core_irq, 1'b0);
      rd(A_STACK_POINTER_GLOBAL_ENABLE, 32'h00);
      rd(A_FLAGS, (i == 2) ? 32'h80 : (32'h10 << i));
      wr(A_FLAGS, 32'h0);
      ctl(4'h1, 8'h00, 8'h00);
      rd(A_STACK_POINTER_GLOBAL_ENABLE, 32'h87);
    end
    @(posedge clk);
    auto <= 1'b0;
    $display("test service entry and return done");
    wr(A_EN, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(A_EDGE, 32'(m) << 3);
      set_pin(1'b0);
      wr(A_FLAGS, 32'h0);
      set_pin(1'b1);
      rd(A_FLAGS, 32'(m & 1));
      wr(A_FLAGS, 32'h0);
      set_pin(1'b0);
      rd(A_FLAGS, 32'(m >> 1));
    end
    $display("test pin edge modes done");
    ctl(4'h4, 8'h5a, 8'h95);
    ctl(4'h8, 8'h00, 8'h4a);
    check(rvalid, 1'b1);
    check(racc, 8'h5a);
    check(rpf, 8'h55);
    rd(A_SAVE, 32'h155a);
    $display("test save and restore done");
    wr(A_EDGE, 32'h10);
    wr(A_EN, 32'h01);
    set_pin(1'b1);
    wr(A_FLAGS, 32'h0);
    ctl(4'h2, 8'h00, 8'h00);
    check(normal_mode, 1'b0);
    @(posedge clk);
    pin <= 1'b0;
    await(1);
    check(wake, 1'b1);
    @(posedge clk);
    #1;
    check(normal_mode, 1'b1);
    check(irq_first, 1'b1);
    check(core_irq, 1'b1);
    @(posedge clk);
    auto <= 1'b1;
    await(0);
    check(vector_load, 1'b1);
    @(posedge clk);
    #1;
    check(irq_first, 1'b0);
    wr(A_FLAGS, 32'h0);
    ctl(4'h1, 8'h00, 8'h00);
    $display("test power down wake done");
    wrap_up();
  end
endmodule : irq_controller_test
